// ---- common/psoam_map.svh ----
`ifndef PSOAM_MAP_SVH
`define PSOAM_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define PSOAM_P1_STATUS_OFS 8'h1f
`define PSOAM_P2_STATUS_OFS 8'h2f
`define PSOAM_P3_STATUS_OFS 8'h3f
`define PSOAM_OAM_ADDR_OFS 8'h40

// ****************************************
// Status field positions
// ****************************************
`define PSOAM_XOVER_BIT 7
`define PSOAM_RSVD_BIT 6
`define PSOAM_POLRV_BIT 5
`define PSOAM_TXFC_BIT 4
`define PSOAM_RXFC_BIT 3
`define PSOAM_SPEED_BIT 2
`define PSOAM_DUPLEX_BIT 1
`define PSOAM_FEF_BIT 0

// ****************************************
// OAM address register fields
// ****************************************
`define PSOAM_REPEAT_MSB 7
`define PSOAM_REPEAT_LSB 5
`define PSOAM_ADDR_MSB 4
`define PSOAM_ADDR_LSB 0
`define PSOAM_ADDR_MIN 5'h01
`define PSOAM_ADDR_MAX 5'h1d

// ****************************************
// Reset values
// ****************************************
`define PSOAM_STATUS_RST 8'h80
`define PSOAM_OAM_ADDR_RST 8'h01

// ****************************************
// Repeat codes
// ****************************************
`define PSOAM_REP_ONE 3'h0
`define PSOAM_REP_TWO 3'h1
`define PSOAM_REP_THREE 3'h2
`define PSOAM_REP_FOUR 3'h5
`define PSOAM_REP_FIVE 3'h4

// ****************************************
// Converter role strap code
// ****************************************
`define PSOAM_ROLE_CENTER 2'h1

`endif

// ---- common/psoam_pkg.sv ----
package psoam_pkg;

  typedef logic [7:0] psoam_byte_t;
  typedef logic [4:0] psoam_addr_t;

  typedef enum logic [1:0] {
    PSOAM_IND_CENTER,
    PSOAM_IND_TERMINAL,
    PSOAM_IND_LOOP_STOP,
    PSOAM_OTHER
  } psoam_frame_e;

endpackage

// ---- src/psoam_regs.sv ----
`timescale 1ns/1ns
`include "psoam_map.svh"

// Overview of operation
// - Status bit 7 selects crossover algorithm, reset 1, transceiver ports.
// - Status bit 5 reads reversed receive polarity; meaningless on port 3.
// - Polarity and crossover bits do not apply on port 3.
// - Status bit 4 reads transmit pause activity.
// - Status bit 3 reads receive pause activity.
// - Status bit 2 reads link speed, 1 for 100Mbps.
// - Status bit 1 reads duplex, 1 for full.
// - Status bit 0 reads far-end fault, port 1 only.
// - OAM bits 7-5 set indication frame copies per change.
// - Copy count applies to three indication frame types only.
// - OAM bits 4-0 hold port 1 address, valid 1 to 29.
// - Port 2 answers at port 1 address plus one.
// - Center role keeps port 1 and converter off until a write of a valid (1 to 29) address.
// - Far-end fault reported only while its disable control is zero.
module psoam_regs
  import psoam_pkg::*;
#(
  parameter int NUM_PORTS = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register access from the serial management port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output psoam_byte_t reg_rdata,
  // Live port state, index 0 is port 1
  input wire logic [NUM_PORTS-1:0] polarity_reversed,
  input wire logic [NUM_PORTS-1:0] tx_pause_active,
  input wire logic [NUM_PORTS-1:0] rx_pause_active,
  input wire logic [NUM_PORTS-1:0] speed_100,
  input wire logic [NUM_PORTS-1:0] full_duplex,
  input wire logic far_end_fault_seen,
  input wire logic far_end_fault_disable,
  // Crossover algorithm select per transceiver port
  output logic [1:0] crossover_algo_select,
  // Converter role straps
  input wire logic converter_role_strap_hi,
  input wire logic converter_role_strap_lo,
  // Transceiver management addressing
  input wire logic [4:0] mgmt_access_addr,
  output logic mgmt_hit_port1,
  output logic mgmt_hit_port2,
  output psoam_addr_t port1_mgmt_addr,
  // Converter control
  output logic port1_enable,
  output logic center_conv_run,
  output logic fef_pattern_enable,
  // Indication frame requests
  input wire logic frame_req,
  input wire psoam_frame_e frame_kind,
  output logic frame_busy,
  output logic frame_send,
  input wire logic frame_done
);

  // ****************************************
  // Storage
  // ****************************************
  logic [1:0] xover;
  logic [2:0] repeat_code;
  psoam_addr_t addr_field;
  logic addr_written;
  logic [1:0] strap_role;
  logic role_caught;
  psoam_byte_t rdata;

  // ****************************************
  // Decode
  // ****************************************
  wire hit_p1 = (reg_addr == `PSOAM_P1_STATUS_OFS);
  wire hit_p2 = (reg_addr == `PSOAM_P2_STATUS_OFS);
  wire hit_p3 = (reg_addr == `PSOAM_P3_STATUS_OFS);
  wire hit_oam = (reg_addr == `PSOAM_OAM_ADDR_OFS);
  wire wr_p1 = reg_wr && hit_p1;
  wire wr_p2 = reg_wr && hit_p2;
  wire wr_oam = reg_wr && hit_oam;
  wire [4:0] wr_addr =
    reg_wdata[`PSOAM_ADDR_MSB:`PSOAM_ADDR_LSB];
  wire addr_ok = (wr_addr >= `PSOAM_ADDR_MIN) &&
    (wr_addr <= `PSOAM_ADDR_MAX);
  wire center_role = (strap_role == `PSOAM_ROLE_CENTER);
  wire fef_live = far_end_fault_seen && !far_end_fault_disable;

  function automatic psoam_byte_t status_of(input int p);
    psoam_byte_t s;
    s = 8'h00;
    s[`PSOAM_RSVD_BIT] = 1'b0;
    if (p < 2) begin
      s[`PSOAM_XOVER_BIT] = xover[p];
      s[`PSOAM_POLRV_BIT] = polarity_reversed[p];
    end
    s[`PSOAM_TXFC_BIT] = tx_pause_active[p];
    s[`PSOAM_RXFC_BIT] = rx_pause_active[p];
    s[`PSOAM_SPEED_BIT] = speed_100[p];
    s[`PSOAM_DUPLEX_BIT] = full_duplex[p];
    if (p == 0) begin
      s[`PSOAM_FEF_BIT] = fef_live;
    end
    return s;
  endfunction

  wire [7:0] oam_value = {repeat_code, addr_field};

  always_comb begin
    rdata = 8'h00;
    if (hit_p1) begin
      rdata = status_of(0);
    end else if (hit_p2) begin
      rdata = status_of(1);
    end else if (hit_p3) begin
      // Port 3 crossover bit is not stored, reads as the reset value
      rdata = status_of(2) | (8'h01 << `PSOAM_XOVER_BIT);
    end else if (hit_oam) begin
      rdata = oam_value;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      xover <= 2'h3;
      repeat_code <= 3'(`PSOAM_OAM_ADDR_RST >> `PSOAM_REPEAT_LSB);
      addr_field <= 5'(`PSOAM_OAM_ADDR_RST);
      addr_written <= 1'b0;
    end else begin
      if (wr_p1) begin
        xover[0] <= reg_wdata[`PSOAM_XOVER_BIT];
      end
      if (wr_p2) begin
        xover[1] <= reg_wdata[`PSOAM_XOVER_BIT];
      end
      if (wr_oam) begin
        repeat_code <= reg_wdata[`PSOAM_REPEAT_MSB:`PSOAM_REPEAT_LSB];
      end
      if (wr_oam && addr_ok) begin
        addr_field <= wr_addr;
        addr_written <= 1'b1;
      end
    end
  end

  // Straps caught once after reset release
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      role_caught <= 1'b0;
      strap_role <= 2'h0;
    end else if (!role_caught) begin
      role_caught <= 1'b1;
      strap_role <= {converter_role_strap_hi, converter_role_strap_lo};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign crossover_algo_select = xover;
  assign port1_mgmt_addr = addr_field;
  assign mgmt_hit_port1 = (mgmt_access_addr == addr_field);
  assign mgmt_hit_port2 = (mgmt_access_addr == addr_field + 5'h01);
  assign port1_enable = role_caught &&
    (!center_role || addr_written);
  assign center_conv_run = role_caught && center_role &&
    addr_written;
  assign fef_pattern_enable = !far_end_fault_disable;

  psoam_repeat u_repeat (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .repeat_code(repeat_code),
    .frame_req(frame_req && center_conv_run),
    .frame_kind(frame_kind),
    .frame_busy(frame_busy),
    .frame_send(frame_send),
    .frame_done(frame_done)
  );

  // ****************************************
  // Checks
  // ****************************************
  sequence seq_addr_write;
    wr_oam && addr_ok;
  endsequence

  AST_XOVER_WRITE: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    wr_p1 |=> crossover_algo_select[0] == $past(reg_wdata[7]))
    else $error("crossover select not written");
  AST_POL_READ: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    reg_rd && hit_p2 |=> reg_rdata[5] == $past(polarity_reversed[1]))
    else $error("polarity bit wrong");
  AST_P3_NA: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    reg_rd && hit_p3 |=> reg_rdata[7] && !reg_rdata[5])
    else $error("port 3 transceiver bits wrong");
  AST_PAUSE_READ: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    reg_rd && hit_p1 |=> reg_rdata[4:3] ==
    $past({tx_pause_active[0], rx_pause_active[0]}))
    else $error("pause bits wrong");
  AST_RXFC: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    reg_rd && hit_p3 |=> reg_rdata[3] == $past(rx_pause_active[2]))
    else $error("receive pause bit wrong");
  AST_SPEED_DUP: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    reg_rd && hit_p2 |=> reg_rdata[2:1] ==
    $past({speed_100[1], full_duplex[1]}))
    else $error("speed or duplex bit wrong");
  AST_DUPLEX: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    reg_rd && hit_p3 |=> reg_rdata[1] == $past(full_duplex[2]))
    else $error("duplex bit wrong");
  AST_FEF: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    reg_rd && (hit_p1 || hit_p2) |=> reg_rdata[0] ==
    $past(hit_p1 && fef_live))
    else $error("far-end fault bit wrong");
  AST_FEF_DIS: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    far_end_fault_disable && reg_rd && hit_p1 |=> !reg_rdata[0])
    else $error("fault shown while disabled");
  AST_RSVD: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    reg_rd && (hit_p1 || hit_p2 || hit_p3) |=> !reg_rdata[6])
    else $error("reserved bit set");
  AST_ADDR: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    seq_addr_write |=> port1_mgmt_addr == $past(wr_addr))
    else $error("address not stored");
  AST_ADDR_BAD: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    wr_oam && !addr_ok |=> $stable(port1_mgmt_addr))
    else $error("invalid address stored");
  AST_P2_ADDR: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    mgmt_access_addr == port1_mgmt_addr + 5'h01 |-> mgmt_hit_port2)
    else $error("port 2 address miss");
  AST_CENTER: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    center_role && !addr_written |-> !port1_enable && !center_conv_run)
    else $error("center converter started early");
  AST_CENTER_GO: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (seq_addr_write and center_role) |=> port1_enable && center_conv_run)
    else $error("center converter not started");
  AST_RESET_VAL: assert property (
    @(posedge sys_clk)
    !reset_n |=> xover == 2'h3 && oam_value == 8'h01)
    else $error("reset values wrong");
  AST_RO_WRITE: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    reg_wr && hit_p3 |=> $stable(xover))
    else $error("port 3 write changed state");

endmodule

// ---- src/psoam_repeat.sv ----
`timescale 1ns/1ns
`include "psoam_map.svh"

// ****************************************
// Copy counter for outgoing OAM frames
// ****************************************
module psoam_repeat
  import psoam_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Setting
  input wire logic [2:0] repeat_code,
  // Frame request
  input wire logic frame_req,
  input wire psoam_frame_e frame_kind,
  output logic frame_busy,
  // Frame send strobes
  output logic frame_send,
  input wire logic frame_done
);

  logic [2:0] remaining;
  logic [2:0] next_remaining;
  logic [2:0] copies;
  logic is_ind;

  function automatic logic [2:0] copies_of(input logic [2:0] code);
    case (code)
      `PSOAM_REP_ONE: copies_of = 3'h1;
      `PSOAM_REP_TWO: copies_of = 3'h2;
      `PSOAM_REP_THREE: copies_of = 3'h3;
      `PSOAM_REP_FOUR: copies_of = 3'h4;
      `PSOAM_REP_FIVE: copies_of = 3'h5;
      default: copies_of = 3'h1;
    endcase
  endfunction

  assign is_ind = (frame_kind != PSOAM_OTHER);
  assign copies = is_ind ? copies_of(repeat_code) : 3'h1;
  assign frame_busy = (remaining != 3'h0);
  assign frame_send = frame_busy;

  always_comb begin
    next_remaining = remaining;
    if (!frame_busy && frame_req) begin
      next_remaining = copies;
    end else if (frame_busy && frame_done) begin
      next_remaining = remaining - 3'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      remaining <= 3'h0;
    end else begin
      remaining <= next_remaining;
    end
  end

  AST_REP_LOAD: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !frame_busy && frame_req |=> remaining == $past(copies))
    else $error("copy count not loaded");
  AST_REP_OTHER: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !frame_busy && frame_req && frame_kind == PSOAM_OTHER
    |=> remaining == 3'h1)
    else $error("non-indication frame sent more than once");

endmodule

// ---- verif/psoam_mgmt_model.sv ----
`timescale 1ns/1ns
`include "psoam_map.svh"

// ****************************************
// Management controller model
// ****************************************
module psoam_mgmt_model
  import psoam_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Register access
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire psoam_byte_t reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    // Reserved status bit kept at its default
    if (a[3:0] == 4'hf) begin
      v[`PSOAM_RSVD_BIT] = 1'b0;
    end
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    // Released lines do not keep the last value
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ns
`include "psoam_map.svh"

module tb
  import psoam_pkg::*;
;
  logic sys_clk, reset_n, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, rv;
  psoam_byte_t reg_rdata;
  logic [14:0] live;
  logic fef_seen, fef_dis, strap_hi, strap_lo, hit1, hit2;
  logic [1:0] xsel;
  logic [4:0] acc_addr;
  psoam_addr_t p1_addr;
  logic p1_en, conv_run, fef_pat;
  logic frame_req, frame_busy, frame_send, frame_done;
  psoam_frame_e frame_kind;
  int miscompares, tests_run;
  logic [7:0] ofs [3];

  psoam_mgmt_model psoam_mgmt_model_inst (.sys_clk(sys_clk),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  psoam_regs #(.NUM_PORTS(3)) psoam_regs_inst (.sys_clk(sys_clk),
    .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .polarity_reversed(live[14:12]), .tx_pause_active(live[11:9]),
    .rx_pause_active(live[8:6]), .speed_100(live[5:3]),
    .full_duplex(live[2:0]), .far_end_fault_seen(fef_seen),
    .far_end_fault_disable(fef_dis), .crossover_algo_select(xsel),
    .converter_role_strap_hi(strap_hi), .converter_role_strap_lo(strap_lo),
    .mgmt_access_addr(acc_addr), .mgmt_hit_port1(hit1),
    .mgmt_hit_port2(hit2), .port1_mgmt_addr(p1_addr),
    .port1_enable(p1_en), .center_conv_run(conv_run),
    .fef_pattern_enable(fef_pat), .frame_req(frame_req),
    .frame_kind(frame_kind), .frame_busy(frame_busy),
    .frame_send(frame_send), .frame_done(frame_done));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic do_reset();
    reset_n = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    @(posedge sys_clk);
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_values();
    for (int i = 0; i < 3; i++) begin
      psoam_mgmt_model_inst.rd(ofs[i], rv);
      chk("status reset", rv, `PSOAM_STATUS_RST);
    end
    psoam_mgmt_model_inst.rd(`PSOAM_OAM_ADDR_OFS, rv);
    chk("oam reset", rv, `PSOAM_OAM_ADDR_RST);
    chk("xover reset", {6'h00, xsel}, 8'h03);
    chk("port1 enable", {7'h00, p1_en}, 8'h00);
    chk("center run", {7'h00, conv_run}, 8'h00);
    frame_req = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    frame_req = 1'b0;
    chk("busy idle", {7'h00, frame_busy}, 8'h00);
  endtask

  task automatic t_status();
    for (int p = 0; p < 3; p++) begin
      for (int f = 0; f < 5; f++) begin
        live = 15'h0001 << ((4 - f) * 3 + p);
        psoam_mgmt_model_inst.rd(ofs[p], rv);
        chk("live bit", rv, (p == 2 && f == 0) ? 8'h80 :
            8'h80 | (8'h20 >> f));
      end
    end
    live = 15'h0000;
    fef_seen = 1'b1;
    psoam_mgmt_model_inst.rd(ofs[0], rv);
    chk("fault p1", rv, 8'h81);
    psoam_mgmt_model_inst.rd(ofs[1], rv);
    chk("fault p2", rv, 8'h80);
    chk("pattern on", {7'h00, fef_pat}, 8'h01);
    fef_dis = 1'b1;
    psoam_mgmt_model_inst.rd(ofs[0], rv);
    chk("fault off", rv, 8'h80);
    chk("pattern off", {7'h00, fef_pat}, 8'h00);
    fef_dis = 1'b0;
    psoam_mgmt_model_inst.wr(ofs[0], 8'h7f);
    chk("xover p1", {6'h00, xsel}, 8'h02);
    psoam_mgmt_model_inst.rd(ofs[0], rv);
    chk("ro ignore", rv, 8'h01);
    psoam_mgmt_model_inst.wr(ofs[1], 8'h00);
    chk("xover p2", {6'h00, xsel}, 8'h00);
    psoam_mgmt_model_inst.wr(ofs[2], 8'h00);
    psoam_mgmt_model_inst.rd(ofs[2], rv);
    chk("port3 fixed", rv, 8'h80);
    psoam_mgmt_model_inst.wr(ofs[0], 8'h80);
    psoam_mgmt_model_inst.wr(ofs[1], 8'h80);
    fef_seen = 1'b0;
  endtask

  task automatic t_oam();
    logic [4:0] bad [3];
    bad = '{5'h00, 5'h1e, 5'h1f};
    psoam_mgmt_model_inst.rd(8'h41, rv);
    chk("unmapped", rv, 8'h00);
    psoam_mgmt_model_inst.wr(`PSOAM_OAM_ADDR_OFS, 8'h25);
    psoam_mgmt_model_inst.rd(`PSOAM_OAM_ADDR_OFS, rv);
    chk("oam write", rv, 8'h25);
    chk("addr out", {3'h0, p1_addr}, 8'h05);
    chk("start", {6'h00, p1_en, conv_run}, 8'h03);
    acc_addr = 5'h05;
    @(posedge sys_clk);
    #1;
    chk("hit p1", {6'h00, hit1, hit2}, 8'h02);
    acc_addr = 5'h06;
    @(posedge sys_clk);
    #1;
    chk("hit p2", {6'h00, hit1, hit2}, 8'h01);
    psoam_mgmt_model_inst.wr(`PSOAM_OAM_ADDR_OFS, 8'h1d);
    acc_addr = 5'h1e;
    @(posedge sys_clk);
    #1;
    chk("hit top", {6'h00, hit1, hit2}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      psoam_mgmt_model_inst.wr(`PSOAM_OAM_ADDR_OFS, {3'h4, bad[i]});
      psoam_mgmt_model_inst.rd(`PSOAM_OAM_ADDR_OFS, rv);
      chk("bad addr", rv, 8'h9d);
    end
  endtask

  task automatic send_frame(input logic [2:0] code, input psoam_frame_e k,
                            input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    psoam_mgmt_model_inst.wr(`PSOAM_OAM_ADDR_OFS, {code, 5'h05});
    @(posedge sys_clk);
    #1;
    frame_kind = k;
    frame_req = 1'b1;
    @(posedge sys_clk);
    #1;
    frame_req = 1'b0;
    chk("send", {7'h00, frame_send}, 8'h01);
    while (frame_busy === 1'b1 && n < 8'h08) begin
      frame_done = 1'b1;
      @(posedge sys_clk);
      #1;
      frame_done = 1'b0;
      n++;
    end
    if (n == 8'h08) begin
      chk("copy wait", n, 8'h00);
      end_sim();
    end else begin
      chk("copies", n, exp);
    end
  endtask

  task automatic t_terminal_role();
    strap_lo = 1'b0;
    do_reset();
    chk("port1 free", {6'h00, p1_en, conv_run}, 8'h02);
    psoam_mgmt_model_inst.wr(`PSOAM_OAM_ADDR_OFS, 8'h05);
    chk("no center", {6'h00, p1_en, conv_run}, 8'h02);
  endtask

  task automatic t_frames();
    logic [2:0] codes [8];
    logic [7:0] cnt [8];
    codes = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h4, 3'h3, 3'h6, 3'h7};
    cnt = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h01, 8'h01, 8'h01};
    for (int i = 0; i < 8; i++) begin
      send_frame(codes[i], psoam_frame_e'(i % 3), cnt[i]);
    end
    send_frame(3'h4, PSOAM_OTHER, 8'h01);
  endtask

  initial begin
    ofs = '{`PSOAM_P1_STATUS_OFS, `PSOAM_P2_STATUS_OFS, `PSOAM_P3_STATUS_OFS};
    miscompares = 0;
    tests_run = 0;
    reset_n = 1'b0;
    live = 15'h0000;
    fef_seen = 1'b0;
    fef_dis = 1'b0;
    strap_hi = 1'b0;
    strap_lo = 1'b1;
    acc_addr = 5'h00;
    frame_req = 1'b0;
    frame_done = 1'b0;
    frame_kind = PSOAM_IND_CENTER;
    do_reset();
    t_reset_values();
    t_status();
    t_oam();
    t_frames();
    do_reset();
    t_reset_values();
    t_terminal_role();
    end_sim();
  end
endmodule
